// ### design/acf_flags.sv
// ALU condition-flag register with core writeback port and APB register access.
//
// Function
// [RQ1] Flag-altering op to flag register updates flags only
// [RQ2] Clearing flag register sets zero, keeps others
// [RQ3] Upper three flag register bits read zero
// [RQ4] Negative flag follows result sign bit
// [RQ5] Signed wrap flag on sign position overflow
// [RQ6] Zero flag set exactly when result zero
// [RQ7] Nibble carry from bit 3 on add/sub
// [RQ8] Carry from top bit on add/sub
// [RQ9] Subtract adds two's complement; inverted borrows
// [RQ10] Rotates load nibble carry from bit 4/3
// [RQ11] Rotates load carry with shifted-out bit
// [RQ12] Bit/swap/move ops leave flags untouched
// [RQ13] Flag register usable as any operand
// [RQ14] Program memory only via program counter
// [RQ15] Indexed literal offset only with extended enable
// [RQ16] Flags commit with result in one writeback
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "acf_params.svh"
module acf_flags #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Execution core request
    input wire logic exec_valid,
    input wire acf_pkg::acf_op_e exec_op,
    input wire logic [WIDTH-1:0] exec_opa,
    input wire logic [WIDTH-1:0] exec_opb,
    input wire logic exec_dest_flags,
    input wire acf_pkg::acf_am_e exec_amode,
    input wire logic exec_prog_access,
    input wire logic exec_prog_via_pc,
    // Writeback to the core
    output logic wb_valid,
    output logic [WIDTH-1:0] wb_data,
    output logic wb_write,
    output logic exec_reject,
    // Flag view for the core and operand reads
    output logic [WIDTH-1:0] flags_operand,
    output logic extended_set_enable
);
    // The flag byte layout assumes an 8-bit datapath; other widths are refused when the design is built.
    if (WIDTH != 8) begin : g_width_check
        $error("acf_flags supports only an 8-bit datapath");
    end

    // ==========================================================================
    // State
    logic [4:0] flags_q;
    logic [4:0] flags_d;
    logic ext_q;
    logic [WIDTH-1:0] wb_data_q;
    logic wb_write_q;
    logic reject_q;
    logic [31:0] prdata_q;
    logic ready_q;
    logic err_q;
    acf_pkg::acf_state_e state_q;

    // Zero-extend the five flags into the byte view; upper bits are not built.
    function automatic logic [7:0] flag_byte(input logic [4:0] f);
        flag_byte = {3'b000, f}; // RQ3
    endfunction : flag_byte

    // The flag register as an operand, like any other file register.
    assign flags_operand = flag_byte(flags_q); // RQ13
    assign extended_set_enable = ext_q;

    // ==========================================================================
    // ALU
    logic [WIDTH-1:0] alu_result;
    logic [4:0] alu_flags;
    logic [4:0] alu_touch;

    acf_alu #(.WIDTH(WIDTH)) u_alu (
        .op(exec_op),
        .opa(exec_opa),
        .opb(exec_opb),
        .carry_in(flags_q[`ACF_BIT_C]),
        .result(alu_result),
        .flags_new(alu_flags),
        .flags_touch(alu_touch)
    );

    // ==========================================================================
    // Request legality: program fetch only by the counter, indexed mode only when enabled.
    wire bad_prog = exec_prog_access && !exec_prog_via_pc; // RQ14
    wire bad_mode = (exec_amode == acf_pkg::ACF_AM_INDEXED) && !ext_q; // RQ15
    wire mode_known = (exec_amode <= acf_pkg::ACF_AM_INDEXED);
    wire exec_ok = exec_valid && !bad_prog && !bad_mode && mode_known;
    wire exec_bad = exec_valid && !exec_ok;

    // A flag-altering op aimed at the flag register drops its result and keeps only the flags.
    wire alters_flags = (alu_touch != 5'h00);
    wire suppress_wb = exec_dest_flags && alters_flags; // RQ1
    // A no-flag op writing the flag register stores its result into the flags.
    wire direct_wr = exec_ok && exec_dest_flags && !alters_flags; // RQ12

    // ==========================================================================
    // APB decode
    wire apb_access = psel && penable;
    // A write lands only at the edge that completes the transfer, never in the wait state.
    wire apb_wr = apb_access && pwrite && ready_q;
    wire hit_flags = (paddr == `ACF_OFF_FLAGS);
    wire hit_ctrl = (paddr == `ACF_OFF_CTRL);
    wire hit_last = (paddr == `ACF_OFF_LAST);
    wire hit_any = hit_flags || hit_ctrl || hit_last;
    wire sw_flag_wr = apb_wr && hit_flags && pstrb[0];
    wire sw_ctrl_wr = apb_wr && hit_ctrl && pstrb[0];

    // Core writes take priority over a same-cycle software write to the flags.
    always_comb begin
        flags_d = flags_q;
        if (sw_flag_wr) begin
            flags_d = pwdata[4:0];
        end
        if (direct_wr) begin
            flags_d = alu_result[4:0];
        end else if (exec_ok) begin
            // CLEAR yields a zero result so Z sets and the untouched flags stay. RQ2
            flags_d = (flags_q & ~alu_touch) | (alu_flags & alu_touch); // RQ16
        end
    end

    // Flag register and writeback stage commit together.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flags_q <= `ACF_FLAGS_RST;
            ext_q <= `ACF_CTRL_RST;
        end else begin
            flags_q <= flags_d; // RQ16
            if (sw_ctrl_wr) begin
                ext_q <= pwdata[0];
            end
        end
    end

    // Writeback stage, one cycle after the request.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wb_data_q <= '0;
            wb_write_q <= 1'b0;
            reject_q <= 1'b0;
            state_q <= acf_pkg::ACF_ST_IDLE;
        end else begin
            wb_write_q <= exec_ok && !suppress_wb && !exec_dest_flags; // RQ1
            reject_q <= exec_bad;
            state_q <= exec_ok ? acf_pkg::ACF_ST_WB : acf_pkg::ACF_ST_IDLE;
            if (exec_ok) begin
                wb_data_q <= alu_result;
            end
        end
    end

    // The writeback state itself is the valid pulse, so no second flop can drift from it.
    assign wb_valid = (state_q == acf_pkg::ACF_ST_WB); // RQ16
    assign wb_data = wb_data_q;
    assign wb_write = wb_write_q;
    assign exec_reject = reject_q;

    // ==========================================================================
    // APB read data and answer; one wait state, so pready rises in the second access cycle.
    wire [31:0] rd_mux = hit_flags ? {24'h000000, flag_byte(flags_q)} : // RQ3
                         hit_ctrl ? {31'h00000000, ext_q} :
                         hit_last ? {22'h000000, reject_q, wb_write_q, wb_data_q} : 32'h00000000;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end else begin
            ready_q <= apb_access && !ready_q;
            err_q <= apb_access && !ready_q && !hit_any;
            if (apb_access && !ready_q && !pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end

    assign pready = ready_q;
    assign pslverr = err_q;
    assign prdata = prdata_q;

    // ==========================================================================
    // Assertions
    wire [4:0] exp_untouched = flags_q & ~alu_touch;

    result_drop_a: assert property (@(posedge clk) disable iff (reset) // RQ1
        (exec_ok && exec_dest_flags && alters_flags) |=> (wb_valid && !wb_write))
        else $error("result written although flag register was destination");
    clear_zero_a: assert property (@(posedge clk) disable iff (reset) // RQ2
        (exec_ok && !sw_flag_wr && exec_op == acf_pkg::ACF_OP_CLEAR)
        |=> (flags_q[`ACF_BIT_Z] && flags_q[4:3] == $past(flags_q[4:3]) && flags_q[1:0] == $past(flags_q[1:0])))
        else $error("clear did not set zero alone");
    upper_zero_a: assert property (@(posedge clk) disable iff (reset) // RQ3
        (ready_q && hit_flags && !pwrite) |-> (prdata[31:5] == 27'h0000000))
        else $error("unimplemented flag bits read nonzero");
    neg_flag_a: assert property (@(posedge clk) disable iff (reset) // RQ4
        (exec_ok && !direct_wr && !sw_flag_wr && exec_op == acf_pkg::ACF_OP_ADD)
        |=> (flags_q[`ACF_BIT_N] == wb_data[7]))
        else $error("negative flag does not match result sign");
    zero_flag_a: assert property (@(posedge clk) disable iff (reset) // RQ6
        (exec_ok && alters_flags && !sw_flag_wr) |=> (flags_q[`ACF_BIT_Z] == (wb_data == 8'h00)))
        else $error("zero flag does not match result");
    sub_carry_a: assert property (@(posedge clk) disable iff (reset) // RQ9
        (exec_ok && !direct_wr && !sw_flag_wr && exec_op == acf_pkg::ACF_OP_SUB)
        |=> (flags_q[`ACF_BIT_C] == ($past(exec_opa) >= $past(exec_opb))))
        else $error("subtract carry is not inverted borrow");
    keep_flags_a: assert property (@(posedge clk) disable iff (reset) // RQ12
        (exec_ok && exec_op == acf_pkg::ACF_OP_NOFLAG && !exec_dest_flags && !sw_flag_wr)
        |=> $stable(flags_q))
        else $error("no-flag op changed flags");
    idx_mode_a: assert property (@(posedge clk) disable iff (reset) // RQ15
        (exec_valid && exec_amode == acf_pkg::ACF_AM_INDEXED && !ext_q) |=> (exec_reject && !wb_valid))
        else $error("indexed mode accepted while disabled");
    commit_a: assert property (@(posedge clk) disable iff (reset) // RQ16
        (exec_ok && !direct_wr && !sw_flag_wr)
        |=> (flags_q == ($past(exp_untouched) | ($past(alu_flags) & $past(alu_touch)))))
        else $error("flags not committed with the result");

    add_cov_c: cover property (@(posedge clk) disable iff (reset) exec_ok && exec_op == acf_pkg::ACF_OP_ADD);
    dest_cov_c: cover property (@(posedge clk) disable iff (reset) exec_ok && suppress_wb);
    apb_cov_c: cover property (@(posedge clk) disable iff (reset) ready_q && hit_flags);
endmodule : acf_flags

// ### design/acf_params.svh
// Constants for the ALU condition-flag block: offsets, field positions, reset values.
`ifndef ACF_PARAMS_SVH
`define ACF_PARAMS_SVH

// ==========================================================================
// Register map
`define ACF_OFF_FLAGS 12'h000
`define ACF_OFF_CTRL 12'h004
`define ACF_OFF_LAST 12'h008

// ==========================================================================
// Flag field positions
`define ACF_BIT_C 0
`define ACF_BIT_NC 1
`define ACF_BIT_Z 2
`define ACF_BIT_OV 3
`define ACF_BIT_N 4
`define ACF_FLAG_MASK 8'h1F

// ==========================================================================
// Reset values
`define ACF_FLAGS_RST 5'h00
`define ACF_CTRL_RST 1'b0

`endif

// ### design/acf_pkg.sv
// Types shared by the ALU condition-flag block.
package acf_pkg;
    // Operation codes presented by the execution core.
    typedef enum logic [3:0] {
        ACF_OP_NONE = 4'h0,
        ACF_OP_ADD = 4'h1,
        ACF_OP_SUB = 4'h2,
        ACF_OP_RRC = 4'h3,
        ACF_OP_RLC = 4'h4,
        ACF_OP_LOGIC = 4'h5,
        ACF_OP_CLEAR = 4'h6,
        ACF_OP_NOFLAG = 4'h7
    } acf_op_e;

    // Addressing modes the operand path may use.
    typedef enum logic [2:0] {
        ACF_AM_INHERENT = 3'h0,
        ACF_AM_LITERAL = 3'h1,
        ACF_AM_DIRECT = 3'h2,
        ACF_AM_INDIRECT = 3'h3,
        ACF_AM_INDEXED = 3'h4
    } acf_am_e;

    // Writeback pipeline state.
    typedef enum logic [1:0] {
        ACF_ST_IDLE = 2'b00,
        ACF_ST_WB = 2'b01
    } acf_state_e;
endpackage : acf_pkg

// ### design/acf_alu.sv
// Combinational ALU producing a result and the five condition flags.
`timescale 1ns/1ps
module acf_alu #(
    parameter int WIDTH = 8
) (
    // Operation
    input wire acf_pkg::acf_op_e op,
    input wire logic [WIDTH-1:0] opa,
    input wire logic [WIDTH-1:0] opb,
    input wire logic carry_in,
    // Results
    output logic [WIDTH-1:0] result,
    output logic [4:0] flags_new,
    output logic [4:0] flags_touch
);
    // The flag taps are fixed bit positions, so any other width is refused when the design is built.
    if (WIDTH != 8) begin : g_width_check
        $error("acf_alu supports only an 8-bit datapath");
    end

    // Subtraction adds the two's complement of the second operand, so carries read as inverted borrows.
    wire [WIDTH-1:0] addend = (op == acf_pkg::ACF_OP_SUB) ? ~opb : opb; // RQ9
    wire add_cin = (op == acf_pkg::ACF_OP_SUB);
    wire [WIDTH:0] sum = {1'b0, opa} + {1'b0, addend} + {{WIDTH{1'b0}}, add_cin};
    wire [4:0] low_sum = {1'b0, opa[3:0]} + {1'b0, addend[3:0]} + {4'h0, add_cin};
    wire is_arith = (op == acf_pkg::ACF_OP_ADD) || (op == acf_pkg::ACF_OP_SUB);
    wire is_rot = (op == acf_pkg::ACF_OP_RRC) || (op == acf_pkg::ACF_OP_RLC);

    // Result selection; the logic op passes operand A as the computed result.
    always_comb begin
        case (op)
            acf_pkg::ACF_OP_ADD, acf_pkg::ACF_OP_SUB: result = sum[WIDTH-1:0];
            acf_pkg::ACF_OP_RRC: result = {carry_in, opa[WIDTH-1:1]};
            acf_pkg::ACF_OP_RLC: result = {opa[WIDTH-2:0], carry_in};
            acf_pkg::ACF_OP_CLEAR: result = '0;
            default: result = opa;
        endcase
    end

    // Flag values; signed wrap when both addends share a sign the sum lacks.
    wire n_f = result[WIDTH-1]; // RQ4
    wire ov_f = (opa[WIDTH-1] == addend[WIDTH-1]) && (sum[WIDTH-1] != opa[WIDTH-1]); // RQ5
    wire z_f = (result == '0); // RQ6
    wire nc_f = is_rot ? ((op == acf_pkg::ACF_OP_RRC) ? opa[4] : opa[3]) : low_sum[4]; // RQ7 RQ10
    wire c_f = is_rot ? ((op == acf_pkg::ACF_OP_RRC) ? opa[0] : opa[WIDTH-1]) : sum[WIDTH]; // RQ8 RQ11
    assign flags_new = {n_f, ov_f, z_f, nc_f, c_f};

    // Which flags each operation alters; the no-flag class touches none.
    always_comb begin
        if (is_arith) begin
            flags_touch = 5'h1F;
        end else if (is_rot) begin
            flags_touch = 5'h17;
        end else if (op == acf_pkg::ACF_OP_LOGIC) begin
            flags_touch = 5'h14;
        end else if (op == acf_pkg::ACF_OP_CLEAR) begin
            // Clearing sets zero only; the negative flag must keep its value.
            flags_touch = 5'h04; // RQ2
        end else begin
            flags_touch = 5'h00; // RQ12
        end
    end
endmodule : acf_alu

// ### verif/acf_core_model.sv
// Behavioural model of the execution core that issues requests to the flag block.
`timescale 1ns/1ps
module acf_core_model (
    // Clock
    input wire logic clk,
    // Request to the flag block
    output logic exec_valid,
    output acf_pkg::acf_op_e exec_op,
    output logic [7:0] exec_opa,
    output logic [7:0] exec_opb,
    output logic exec_dest_flags,
    output acf_pkg::acf_am_e exec_amode,
    output logic exec_prog_access,
    output logic exec_prog_via_pc
);
    // ==========================================================================
    // Idle values
    // Everything starts quiet so the block sees no request during reset.
    initial begin
        exec_valid = 1'b0;
        exec_op = acf_pkg::ACF_OP_NONE;
        exec_opa = 8'h00;
        exec_opb = 8'h00;
        exec_dest_flags = 1'b0;
        exec_amode = acf_pkg::ACF_AM_DIRECT;
        exec_prog_access = 1'b0;
        exec_prog_via_pc = 1'b0;
    end

    // One request held for exactly one taking edge; operands are inverted after it so stale data never looks valid.
    task automatic issue(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b, input logic dest,
                         input logic [2:0] am, input logic prog, input logic via_pc);
        @(posedge clk);
        exec_valid <= 1'b1;
        exec_op <= acf_pkg::acf_op_e'(op);
        exec_opa <= a;
        exec_opb <= b;
        exec_dest_flags <= dest;
        exec_amode <= acf_pkg::acf_am_e'(am);
        exec_prog_access <= prog;
        exec_prog_via_pc <= via_pc;
        @(posedge clk);
        exec_valid <= 1'b0;
        exec_opa <= ~a;
        exec_opb <= ~b;
    endtask : issue
endmodule : acf_core_model

// ### verif/tb_top.sv
// Self-checking testbench for the ALU condition-flag block.
`timescale 1ns/1ps
module tb_top;
    // ==========================================================================
    // Signals
    logic clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err, exec_valid, exec_dest_flags, exec_prog_access, exec_prog_via_pc;
    acf_pkg::acf_op_e exec_op;
    acf_pkg::acf_am_e exec_amode;
    logic [7:0] exec_opa, exec_opb, wb_data, flags_operand;
    logic wb_valid, wb_write, exec_reject, ext_en;
    logic [4:0] fl;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    // The rotate left leaves the negative flag set so that the clear which follows must keep it.
    logic [20:0] vec [11] = '{{4'h1, 8'h7F, 8'h01, 1'b0}, {4'h1, 8'hFF, 8'h01, 1'b0}, {4'h2, 8'h05, 8'h05, 1'b0},
                              {4'h2, 8'h00, 8'h01, 1'b0}, {4'h3, 8'h11, 8'h00, 1'b0}, {4'h4, 8'hC8, 8'h00, 1'b0},
                              {4'h6, 8'h5A, 8'h00, 1'b1}, {4'h1, 8'h80, 8'h80, 1'b1}, {4'h7, 8'h3C, 8'h00, 1'b0},
                              {4'h5, 8'h80, 8'h00, 1'b0}, {4'h7, 8'h35, 8'h00, 1'b1}};

    // ==========================================================================
    // Clock, timeout and instances
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // A hung handshake ends the run here rather than in the simulator.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            final_report();
        end
    end
    acf_flags i_acf_flags (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .exec_valid(exec_valid), .exec_op(exec_op), .exec_opa(exec_opa), .exec_opb(exec_opb),
        .exec_dest_flags(exec_dest_flags), .exec_amode(exec_amode), .exec_prog_access(exec_prog_access),
        .exec_prog_via_pc(exec_prog_via_pc), .wb_valid(wb_valid), .wb_data(wb_data), .wb_write(wb_write),
        .exec_reject(exec_reject), .flags_operand(flags_operand), .extended_set_enable(ext_en));
    acf_core_model i_acf_core_model (.clk(clk), .exec_valid(exec_valid), .exec_op(exec_op),
        .exec_opa(exec_opa), .exec_opb(exec_opb), .exec_dest_flags(exec_dest_flags), .exec_amode(exec_amode),
        .exec_prog_access(exec_prog_access), .exec_prog_via_pc(exec_prog_via_pc));

    // ==========================================================================
    // Tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // APB transfer held until pready is sampled high at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reference flags and result; the model is kept apart from the block's own arithmetic.
    task automatic run(input logic [20:0] v);
        logic [3:0] op;
        logic [7:0] a, b, bb, r;
        logic [8:0] s;
        logic [4:0] h;
        {op, a, b} = v[20:1];
        bb = (op == 4'h2) ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, op == 4'h2};
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, op == 4'h2};
        r = s[7:0];
        case (op)
            4'h1, 4'h2: fl = {r[7], a[7] == bb[7] && r[7] != a[7], r == 8'h00, h[4], s[8]};
            4'h3: begin
                r = {fl[0], a[7:1]};
                fl = {r[7], fl[3], r == 8'h00, a[4], a[0]};
            end
            4'h4: begin
                r = {a[6:0], fl[0]};
                fl = {r[7], fl[3], r == 8'h00, a[3], a[7]};
            end
            4'h6: fl[2] = 1'b1;
            4'h5: begin
                r = a;
                fl = {r[7], fl[3], r == 8'h00, fl[1:0]};
            end
            default: begin
                // A no-flag op passes its operand; aimed at the flag register it loads the low five bits.
                r = a;
                if (v[0]) fl = a[4:0];
            end
        endcase
        i_acf_core_model.issue(op, a, b, v[0], 3'h2, 1'b0, 1'b0);
        #1;
        check("wb_valid", {31'h0, wb_valid}, 32'h1);
        check("wb_write", {31'h0, wb_write}, {31'h0, ~v[0]});
        if (!v[0]) check("wb_data", {24'h0, wb_data}, {24'h0, r});
        check("flags", {24'h0, flags_operand}, {27'h0, fl});
    endtask : run

    task automatic refuse(input logic [2:0] am, input logic prog, input logic via);
        i_acf_core_model.issue(4'h1, 8'h01, 8'h01, 1'b0, am, prog, via);
        #1;
        check("reject", {30'h0, exec_reject, wb_valid}, 32'h2);
        check("flags_kept", {24'h0, flags_operand}, {27'h0, fl});
    endtask : refuse

    task automatic final_report();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // ==========================================================================
    // Main sequence
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {3'b100, 45'h0};
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        check("flags_rst", rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check("ctrl_rst", rd, 32'h0);
        apb(1'b1, 12'h000, 32'hFFFF_FFFF);
        apb(1'b0, 12'h000, 32'h0);
        check("flags_rw", rd, 32'h1F);
        apb(1'b0, 12'h00C, 32'h0);
        check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        fl = 5'h1F;
        foreach (vec[i]) run(vec[i]);
        apb(1'b0, 12'h000, 32'h0);
        check("flags_read", rd, {27'h0, fl});
        apb(1'b0, 12'h008, 32'h0);
        check("last", rd, 32'h0000_0035);
        refuse(3'h4, 1'b0, 1'b0);
        refuse(3'h5, 1'b0, 1'b0);
        refuse(3'h2, 1'b1, 1'b0);
        apb(1'b1, 12'h004, 32'h1);
        #1;
        check("ext_en", {31'h0, ext_en}, 32'h1);
        i_acf_core_model.issue(4'h7, 8'h00, 8'h00, 1'b0, 3'h4, 1'b1, 1'b1);
        #1;
        check("indexed_ok", {30'h0, exec_reject, wb_valid}, 32'h1);
        final_report();
    end
endmodule : tb_top
